/* File: hw/mise_alu.sv */
`timescale 1ns/1ps
// Combinational datapath for subtract and nibble swap.
module mise_alu
   import mise_pkg::*;
(
   input  wire logic [3:0] op,
   input  wire logic [7:0] src,
   input  wire logic [7:0] acc,
   output logic      [7:0] result,
   output logic            zero,
   output logic            digit_carry,
   output logic            carry,
   output logic            flags_we
);

   logic [10:0] diff;  // Packed subtract outcome.

   // The same subtract serves both forms; only the source of the minuend differs.
   always_comb begin
      diff        = mise_subtract(src, acc);
      result      = src;
      zero        = diff[10];
      digit_carry = diff[9];
      carry       = diff[8];
      flags_we    = 1'b0;
      case (op)
         MISE_OP_REG_SUB, MISE_OP_IMM_SUB: begin
            result   = diff[7:0];
            flags_we = 1'b1;
         end
         MISE_OP_SWAP: begin
            result = mise_swap(src);
         end
         default: begin
            result = src;
         end
      endcase
   end

endmodule // mise_alu

/* File: hw/mise_core.sv */
`timescale 1ns/1ps
module mise_core
   import mise_pkg::*;
(
   input  wire logic                                pclk,
   input  wire logic                                presetn,
   input  wire logic                                psel,
   input  wire logic                                penable,
   input  wire logic                                pwrite,
   input  wire logic [mise_pkg::MISE_PADDR_W-1:0]   paddr,
   input  wire logic [mise_pkg::MISE_PDATA_W-1:0]   pwdata,
   output logic                                     pready,
   output logic      [mise_pkg::MISE_PDATA_W-1:0]   prdata,
   output logic                                     pslverr,
   output logic      [7:0]                          timer0_mode_register,
   output logic                                     halt_mode,
   output logic                                     watchdog_clear
);
   import mise_pkg::*;

   // Execution sequence of one issued instruction.
   typedef enum logic [1:0] {
      MISE_ST_IDLE,
      MISE_ST_FETCH,
      MISE_ST_EXEC
   } mise_state_t;

   mise_state_t state;                      // Current execution step.
   logic [3:0]  instr_op;                   // Latched opcode.
   logic        instr_dest;                 // Latched destination bit.
   logic [7:0]  instr_operand;              // Latched register, page index or immediate.
   logic [7:0]  accumulator;                // Working register.
   logic        carry_flag;                 // Carry, set means no borrow.
   logic        digit_carry_flag;           // Carry out of the low nibble.
   logic        zero_flag;                  // Result was zero.
   logic        timeout_flag;               // Active-low timeout status bit.
   logic        powerdown_flag;             // Active-low powerdown status bit.
   logic [6:0]  mem_addr;                   // Software pointer into data memory.
   logic [4:0]  spc_addr;                   // Software pointer into the special page.

   logic        access;                     // Access phase still waiting for pready.
   logic        done;                       // Completing edge of an APB transfer.
   logic        instr_wr;                   // Access phase of an instruction issue.
   logic        exec;                       // Completing edge of an instruction.
   logic        run;                        // Instruction is allowed to act.
   logic        spc_ok;                     // Page operand lies inside the page.
   logic        mem_we;                     // Data-memory write strobe.
   logic [6:0]  mem_a;                      // Data-memory address.
   logic [7:0]  mem_wd;                     // Data-memory write data.
   logic [7:0]  mem_rd;                     // Data-memory read data.
   logic        spc_we;                     // Special-page write strobe.
   logic [4:0]  spc_a;                      // Special-page address.
   logic [7:0]  spc_wd;                     // Special-page write data.
   logic [7:0]  spc_rd;                     // Special-page read data.
   logic [7:0]  alu_src;                    // Minuend or swap source.
   logic [7:0]  alu_res;                    // Datapath result.
   logic        alu_z;                      // Zero from the datapath.
   logic        alu_dc;                     // Digit carry from the datapath.
   logic        alu_c;                      // Carry from the datapath.
   logic        alu_fwe;                    // Datapath wants the flags updated.
   logic [31:0] next_prdata;                // Read word chosen by address.
   logic        next_pslverr;               // Address is not mapped.

   // APB phase decode. Register writes act on the edge where pready is seen high; an instruction is latched at its first access edge.
   assign access   = psel && penable && !pready;
   assign done     = psel && penable && pready;
   assign instr_wr = access && pwrite && (paddr == MISE_REG_INSTR);
   assign exec     = (state == MISE_ST_EXEC) && done;
   // A halted core ignores further instructions until software wakes it.
   assign run      = exec && !halt_mode;
   assign spc_ok   = 32'(instr_operand) < MISE_SPC_DEPTH;

   // Instruction sequencer: latch, read the operand memories, then act.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state         <= MISE_ST_IDLE;
         instr_op      <= MISE_OP_NOP;
         instr_dest    <= 1'b0;
         instr_operand <= MISE_BYTE_RST;
      end else begin
         case (state)
            MISE_ST_IDLE: begin
               if (instr_wr) begin
                  instr_op      <= pwdata[MISE_OP_MSB:MISE_OP_LSB];
                  instr_dest    <= pwdata[MISE_DEST_BIT];
                  instr_operand <= pwdata[MISE_OPND_MSB:MISE_OPND_LSB];
                  state         <= MISE_ST_FETCH;
               end
            end
            MISE_ST_FETCH: begin
               // The operand word is read during this step.
               state <= MISE_ST_EXEC;
            end
            MISE_ST_EXEC: begin
               if (done) begin
                  state <= MISE_ST_IDLE;
               end
            end
            default: begin
               state <= MISE_ST_IDLE;
            end
         endcase
      end
   end

   // Ready comes one cycle into the access phase; an issue waits for its operand fetch.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= access && (!instr_wr || (state == MISE_ST_FETCH));
      end
   end

   // Read data and error are captured with pready so they stand while it is high.
   always_comb begin
      next_prdata  = '0;
      next_pslverr = 1'b0;
      case (paddr)
         MISE_REG_INSTR:    next_prdata = {16'h0000, instr_operand, 3'h0, instr_dest, instr_op};
         MISE_REG_ACC:      next_prdata = {24'h000000, accumulator};
         MISE_REG_STATUS: begin
            next_prdata[MISE_ST_C]    = carry_flag;
            next_prdata[MISE_ST_DC]   = digit_carry_flag;
            next_prdata[MISE_ST_Z]    = zero_flag;
            next_prdata[MISE_ST_PD]   = powerdown_flag;
            next_prdata[MISE_ST_TO]   = timeout_flag;
            next_prdata[MISE_ST_HALT] = halt_mode;
            next_prdata[MISE_ST_BUSY] = (state != MISE_ST_IDLE);
         end
         MISE_REG_T0MODE:   next_prdata = {24'h000000, timer0_mode_register};
         MISE_REG_MEM_ADDR: next_prdata = {25'h0000000, mem_addr};
         MISE_REG_MEM_DATA: next_prdata = {24'h000000, mem_rd};
         MISE_REG_SPC_ADDR: next_prdata = {27'h0000000, spc_addr};
         MISE_REG_SPC_DATA: next_prdata = {24'h000000, spc_rd};
         MISE_REG_CTRL:     next_prdata = '0;
         default: begin
            // Unmapped offsets read zero and flag a slave error.
            next_pslverr = 1'b1;
         end
      endcase
   end

   // Read path registers.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= '0;
         pslverr <= 1'b0;
      end else if (access) begin
         prdata  <= pwrite ? '0 : next_prdata;
         pslverr <= next_pslverr;
      end else begin
         prdata  <= '0;
         pslverr <= 1'b0;
      end
   end

   // Memory ports: the core owns them while an instruction runs, software otherwise.
   // Because pready stalls the bus during an issue, the two owners never collide.
   always_comb begin
      mem_a  = (state == MISE_ST_IDLE) ? mem_addr : instr_operand[6:0];
      mem_we = done && pwrite && (paddr == MISE_REG_MEM_DATA);
      mem_wd = pwdata[7:0];
      if (run && instr_dest &&
          ((instr_op == MISE_OP_REG_SUB) || (instr_op == MISE_OP_SWAP))) begin
         mem_we = 1'b1;
         mem_wd = alu_res;
      end
      spc_a  = (state == MISE_ST_IDLE) ? spc_addr : instr_operand[4:0];
      spc_we = done && pwrite && (paddr == MISE_REG_SPC_DATA);
      spc_wd = pwdata[7:0];
      if (run && (instr_op == MISE_OP_SPC_STORE) && spc_ok) begin
         spc_we = 1'b1;
         spc_wd = accumulator;
      end
   end

   // Data memory of register operands.
   mise_ram #(
      .DEPTH (MISE_DATA_DEPTH),
      .AW    (MISE_DATA_AW),
      .DW    (8)
   ) u_data_ram (
      .clk   (pclk),
      .we    (mem_we),
      .addr  (mem_a),
      .wdata (mem_wd),
      .rdata (mem_rd)
   );

   // Special register page.
   mise_ram #(
      .DEPTH (MISE_SPC_DEPTH),
      .AW    (MISE_SPC_AW),
      .DW    (8)
   ) u_spc_ram (
      .clk   (pclk),
      .we    (spc_we),
      .addr  (spc_a),
      .wdata (spc_wd),
      .rdata (spc_rd)
   );

   // The immediate form takes its minuend from the operand, the others from memory.
   assign alu_src = (instr_op == MISE_OP_IMM_SUB) ? instr_operand : mem_rd;

   // Subtract and swap datapath.
   mise_alu u_alu (
      .op          (instr_op),
      .src         (alu_src),
      .acc         (accumulator),
      .result      (alu_res),
      .zero        (alu_z),
      .digit_carry (alu_dc),
      .carry       (alu_c),
      .flags_we    (alu_fwe)
   );

   // Accumulator: software writes, loads, and results routed to it.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         accumulator <= MISE_BYTE_RST;
      end else if (run) begin
         case (instr_op)
            MISE_OP_SPC_LOAD: begin
               // A page index past the end loads zero rather than junk.
               accumulator <= spc_ok ? spc_rd : MISE_BYTE_RST;
            end
            MISE_OP_REG_SUB, MISE_OP_SWAP: begin
               if (!instr_dest) begin
                  accumulator <= alu_res;
               end
            end
            MISE_OP_IMM_SUB: begin
               accumulator <= alu_res;
            end
            default: begin
               accumulator <= accumulator;
            end
         endcase
      end else if (done && pwrite && (paddr == MISE_REG_ACC)) begin
         accumulator <= pwdata[7:0];
      end
   end

   // Arithmetic flags change only for the subtracts; software may also preset them.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         carry_flag       <= 1'b0;
         digit_carry_flag <= 1'b0;
         zero_flag        <= 1'b0;
      end else if (run && alu_fwe) begin
         carry_flag       <= alu_c;
         digit_carry_flag <= alu_dc;
         zero_flag        <= alu_z;
      end else if (done && pwrite && (paddr == MISE_REG_STATUS)) begin
         carry_flag       <= pwdata[MISE_ST_C];
         digit_carry_flag <= pwdata[MISE_ST_DC];
         zero_flag        <= pwdata[MISE_ST_Z];
      end
   end

   // Power flags and halt mode. Only the halt instruction touches the power flags.
   // The wake command leaves the flags as halt left them, so software can see why.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timeout_flag   <= MISE_TO_RST;
         powerdown_flag <= MISE_PD_RST;
         halt_mode      <= 1'b0;
      end else if (run && (instr_op == MISE_OP_HALT)) begin
         timeout_flag   <= 1'b1;
         powerdown_flag <= 1'b0;
         halt_mode      <= 1'b1;
      end else if (done && pwrite && (paddr == MISE_REG_CTRL) && pwdata[MISE_CTRL_WAKE]) begin
         halt_mode <= 1'b0;
      end
   end

   // One-cycle pulse to the watchdog that zeroes its counter and prescaler.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         watchdog_clear <= 1'b0;
      end else begin
         watchdog_clear <= run && (instr_op == MISE_OP_HALT);
      end
   end

   // Timer0 mode register, loaded only by its instruction.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer0_mode_register <= MISE_BYTE_RST;
      end else if (run && (instr_op == MISE_OP_TMODE)) begin
         timer0_mode_register <= accumulator;
      end
   end

   // Software pointers into the two memories.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_addr <= 7'h00;
         spc_addr <= 5'h00;
      end else if (done && pwrite) begin
         if (paddr == MISE_REG_MEM_ADDR) begin
            mem_addr <= pwdata[6:0];
         end
         if (paddr == MISE_REG_SPC_ADDR) begin
            spc_addr <= pwdata[4:0];
         end
      end
   end

endmodule // mise_core

/* File: hw/mise_pkg.sv */
// Shared constants for the instruction-subset execution block.
package mise_pkg;

   // APB address width and data width.
   localparam int unsigned MISE_PADDR_W  = 8;
   localparam int unsigned MISE_PDATA_W  = 32;

   // Register byte offsets on the APB slave.
   localparam logic [7:0]  MISE_REG_INSTR    = 8'h00;  // Instruction issue register.
   localparam logic [7:0]  MISE_REG_ACC      = 8'h04;  // Accumulator.
   localparam logic [7:0]  MISE_REG_STATUS   = 8'h08;  // Flags and core state.
   localparam logic [7:0]  MISE_REG_T0MODE   = 8'h0C;  // Timer0 mode register, read only.
   localparam logic [7:0]  MISE_REG_MEM_ADDR = 8'h10;  // Data-memory pointer for software.
   localparam logic [7:0]  MISE_REG_MEM_DATA = 8'h14;  // Data-memory word at the pointer.
   localparam logic [7:0]  MISE_REG_SPC_ADDR = 8'h18;  // Special-page pointer for software.
   localparam logic [7:0]  MISE_REG_SPC_DATA = 8'h1C;  // Special-page word at the pointer.
   localparam logic [7:0]  MISE_REG_CTRL     = 8'h20;  // Control, write only.

   // Opcode encodings in the instruction register.
   localparam logic [3:0]  MISE_OP_NOP       = 4'h0;
   localparam logic [3:0]  MISE_OP_SPC_STORE = 4'h1;  // Special page store.
   localparam logic [3:0]  MISE_OP_SPC_LOAD  = 4'h2;  // Special page load.
   localparam logic [3:0]  MISE_OP_REG_SUB   = 4'h3;  // Register subtract.
   localparam logic [3:0]  MISE_OP_IMM_SUB   = 4'h4;  // Immediate subtract.
   localparam logic [3:0]  MISE_OP_SWAP      = 4'h5;  // Nibble swap.
   localparam logic [3:0]  MISE_OP_HALT      = 4'h6;  // Halt entry.
   localparam logic [3:0]  MISE_OP_TMODE     = 4'h7;  // Timer mode load.

   // Field positions inside the instruction register.
   localparam int unsigned MISE_OP_LSB    = 0;
   localparam int unsigned MISE_OP_MSB    = 3;
   localparam int unsigned MISE_DEST_BIT  = 4;
   localparam int unsigned MISE_OPND_LSB  = 8;
   localparam int unsigned MISE_OPND_MSB  = 15;

   // Bit positions in the status register.
   localparam int unsigned MISE_ST_C      = 0;
   localparam int unsigned MISE_ST_DC     = 1;
   localparam int unsigned MISE_ST_Z      = 2;
   localparam int unsigned MISE_ST_PD     = 3;
   localparam int unsigned MISE_ST_TO     = 4;
   localparam int unsigned MISE_ST_HALT   = 5;
   localparam int unsigned MISE_ST_BUSY   = 6;

   // Bit position of the wake command in the control register.
   localparam int unsigned MISE_CTRL_WAKE = 0;

   // Memory geometry.
   localparam int unsigned MISE_DATA_DEPTH = 128;
   localparam int unsigned MISE_DATA_AW    = 7;
   localparam int unsigned MISE_SPC_DEPTH  = 22;
   localparam int unsigned MISE_SPC_AW     = 5;

   // Reset values.
   localparam logic [7:0]  MISE_BYTE_RST  = 8'h00;
   localparam logic        MISE_TO_RST    = 1'b1;
   localparam logic        MISE_PD_RST    = 1'b1;

   // Subtract minuend minus subtrahend; returns {zero, digit carry, carry, result}.
   // Carry and digit carry mean no borrow, as in an add of the complement plus one.
   function automatic logic [10:0] mise_subtract(input logic [7:0] minuend,
                                                 input logic [7:0] subtrahend);
      logic [8:0] full;
      logic [4:0] low;
      full = {1'b0, minuend} + {1'b0, ~subtrahend} + 9'h001;
      low  = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + 5'h01;
      return {(full[7:0] == 8'h00), low[4], full[8], full[7:0]};
   endfunction

   // Exchange the two nibbles of a byte.
   function automatic logic [7:0] mise_swap(input logic [7:0] value);
      return {value[3:0], value[7:4]};
   endfunction

endpackage

/* File: hw/mise_ram.sv */
`timescale 1ns/1ps
// Single-port memory with registered read data; out-of-range reads give zero.
module mise_ram #(
   parameter int unsigned DEPTH = 128,
   parameter int unsigned AW    = 7,
   parameter int unsigned DW    = 8
) (
   input  wire logic          clk,
   input  wire logic          we,
   input  wire logic [AW-1:0] addr,
   input  wire logic [DW-1:0] wdata,
   output logic      [DW-1:0] rdata
);

   logic [DW-1:0] mem [DEPTH];  // Storage array, not reset, like a real RAM.

   // Write port; an address past the end is dropped so a short array never aliases.
   always_ff @(posedge clk) begin
      if (we && (32'(addr) < DEPTH)) begin
         mem[addr] <= wdata;
      end
   end

   // Read port, registered so the word is ready one cycle after the address.
   always_ff @(posedge clk) begin
      if (32'(addr) < DEPTH) begin
         rdata <= mem[addr];
      end else begin
         rdata <= '0;
      end
   end

endmodule // mise_ram

/* File: tb/mise_core_assertions.sv */
`timescale 1ns/1ps
// Watches the bus answers and the core outputs of the execution block.
module mise_core_assertions
   import mise_pkg::*;
(
   input wire logic                                pclk,
   input wire logic                                presetn,
   input wire logic                                psel,
   input wire logic                                penable,
   input wire logic                                pwrite,
   input wire logic [mise_pkg::MISE_PADDR_W-1:0]   paddr,
   input wire logic [mise_pkg::MISE_PDATA_W-1:0]   pwdata,
   input wire logic                                pready,
   input wire logic [mise_pkg::MISE_PDATA_W-1:0]   prdata,
   input wire logic                                pslverr,
   input wire logic [7:0]                          timer0_mode_register,
   input wire logic                                halt_mode,
   input wire logic                                watchdog_clear
);
   logic done_wr;   // A write completes at this edge.
   logic ins_halt;  // A halt instruction completes at this edge.
   logic ins_tmode; // A timer mode load completes at this edge.
   assign done_wr   = psel && penable && pready && pwrite;
   assign ins_halt  = done_wr && paddr == MISE_REG_INSTR && pwdata[3:0] == MISE_OP_HALT;
   assign ins_tmode = done_wr && paddr == MISE_REG_INSTR && pwdata[3:0] == MISE_OP_TMODE;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   plain_wait_a: assert property (psel && !penable && paddr != MISE_REG_INSTR |=> !pready ##1 pready)
      else $error("Register access answered with the wrong wait.");
   instr_wait_a: assert property (psel && !penable && pwrite && paddr == MISE_REG_INSTR |=> !pready [*2] ##1 pready)
      else $error("Instruction write answered with the wrong wait.");
   halt_entry_a: assert property (ins_halt && !halt_mode |=> halt_mode && watchdog_clear)
      else $error("Halt did not enter halt mode with a watchdog clear.");
   wdog_pulse_a: assert property (watchdog_clear |=> !watchdog_clear)
      else $error("Watchdog clear lasted more than one cycle.");
   wdog_cause_a: assert property (watchdog_clear |-> $past(ins_halt))
      else $error("Watchdog clear without a halt instruction.");
   halt_hold_a: assert property (halt_mode && !(done_wr && paddr == MISE_REG_CTRL && pwdata[0]) |=> halt_mode)
      else $error("Halt mode left without a wake command.");
   tmode_cause_a: assert property (!$stable(timer0_mode_register) |-> $past(ins_tmode) && !$past(halt_mode))
      else $error("Timer mode changed without a timer mode load.");
   t0_read_a: assert property (pready && !pwrite && paddr == MISE_REG_T0MODE |-> prdata == {24'h000000, timer0_mode_register} && !pslverr)
      else $error("Timer mode read back differs from the output.");
   unmapped_a: assert property (pready && paddr > MISE_REG_CTRL |-> pslverr && prdata == 32'h00000000)
      else $error("Unmapped access not refused.");
endmodule // mise_core_assertions

/* File: tb/tb.sv */
`timescale 1ns/1ps
module tb;
   import mise_pkg::*;
   logic        pclk = 1'b0;     // Bus clock, 100 MHz.
   logic        presetn = 1'b0;  // Reset, active low.
   logic        psel = 1'b0;     // Bus select.
   logic        penable = 1'b0;  // Bus access phase.
   logic        pwrite = 1'b0;   // Bus direction.
   logic [7:0]  paddr = 8'h00;   // Bus address.
   logic [31:0] pwdata = 32'h0;  // Bus write data.
   logic        pready;          // Slave answer.
   logic [31:0] prdata;          // Slave read data.
   logic        pslverr;         // Slave refusal.
   logic [7:0]  t0m;             // Timer0 mode output.
   logic        halt_mode;       // Halt state output.
   logic        wdc;             // Watchdog clear pulse output.
   logic [31:0] rd;              // Last read data.
   logic [10:0] ex;              // Expected flags and result.
   logic [7:0]  mv [4] = '{8'h05, 8'h06, 8'h05, 8'h10}; // Minuends.
   logic [7:0]  sv [4] = '{8'h06, 8'h05, 8'h05, 8'h01}; // Subtrahends.
   int          miscompares = 0; // Mismatch count.
   int          tests_run = 0;   // Comparison count.
   int          cycles = 0;      // Hang guard.
   always #5 pclk = ~pclk;
   mise_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .timer0_mode_register(t0m), .halt_mode(halt_mode),
      .watchdog_clear(wdc));
   // Reference subtract, worked by plain arithmetic: {zero, digit carry, carry, result}.
   function automatic logic [10:0] exp_sub(input logic [7:0] m, input logic [7:0] s);
      logic [7:0] r;
      r = m - s;
      return {r == 8'h00, m[3:0] >= s[3:0], m >= s, r};
   endfunction
   task print_verdict;
      $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // One bus transfer; the request is held until pready is seen high.
   task apb(input logic [7:0] a, input logic [31:0] d, input logic w);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rd_chk(input logic [7:0] a, input logic [7:0] e);
      apb(a, 32'h0, 1'b0);
      check(rd, {24'h000000, e});
   endtask
   // Status is compared on its flag and halt bits only; the busy bit is masked off.
   task st_chk(input logic [7:0] e);
      apb(MISE_REG_STATUS, 32'h0, 1'b0);
      check(rd & 32'h3F, {24'h000000, e});
   endtask
   task ex_op(input logic [3:0] op, input logic d, input logic [7:0] o);
      apb(MISE_REG_INSTR, {16'h0000, o, 3'b000, d, op}, 1'b1);
   endtask
   // A hang is cut short and counted as a mismatch.
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         print_verdict;
      end
   end
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      st_chk(8'h18);
      rd_chk(8'h24, 8'h00);
      apb(MISE_REG_ACC, 32'hAA, 1'b1);
      ex_op(MISE_OP_SPC_STORE, 1'b0, 8'd21);
      apb(MISE_REG_SPC_ADDR, 32'd21, 1'b1);
      rd_chk(MISE_REG_SPC_DATA, 8'hAA);
      apb(MISE_REG_ACC, 32'h0, 1'b1);
      ex_op(MISE_OP_SPC_LOAD, 1'b0, 8'd21);
      rd_chk(MISE_REG_ACC, 8'hAA);
      st_chk(8'h18);
      apb(MISE_REG_MEM_ADDR, 32'd127, 1'b1);
      for (int i = 0; i < 4; i++) begin
         ex = exp_sub(mv[i], sv[i]);
         for (int d = 0; d < 2; d++) begin
            apb(MISE_REG_MEM_DATA, {24'h0, mv[i]}, 1'b1);
            apb(MISE_REG_ACC, {24'h0, sv[i]}, 1'b1);
            ex_op(MISE_OP_REG_SUB, d[0], 8'd127);
            rd_chk(d ? MISE_REG_MEM_DATA : MISE_REG_ACC, ex[7:0]);
            rd_chk(d ? MISE_REG_ACC : MISE_REG_MEM_DATA, d ? sv[i] : mv[i]);
            st_chk({5'b00011, ex[10:8]});
         end
         apb(MISE_REG_ACC, {24'h0, sv[i]}, 1'b1);
         ex_op(MISE_OP_IMM_SUB, 1'b0, mv[i]);
         rd_chk(MISE_REG_ACC, ex[7:0]);
         st_chk({5'b00011, ex[10:8]});
      end
      apb(MISE_REG_STATUS, 32'h5, 1'b1);
      apb(MISE_REG_MEM_DATA, 32'hA5, 1'b1);
      ex_op(MISE_OP_SWAP, 1'b0, 8'd127);
      rd_chk(MISE_REG_ACC, 8'h5A);
      rd_chk(MISE_REG_MEM_DATA, 8'hA5);
      ex_op(MISE_OP_SWAP, 1'b1, 8'd127);
      rd_chk(MISE_REG_MEM_DATA, 8'h5A);
      st_chk(8'h1D);
      apb(MISE_REG_ACC, 32'h3C, 1'b1);
      ex_op(MISE_OP_TMODE, 1'b0, 8'h00);
      // Outputs are updated at the completing edge, so look one edge later.
      @(posedge pclk);
      check(t0m, 32'h3C);
      rd_chk(MISE_REG_T0MODE, 8'h3C);
      rd_chk(MISE_REG_ACC, 8'h3C);
      st_chk(8'h1D);
      ex_op(MISE_OP_HALT, 1'b0, 8'h00);
      @(posedge pclk);
      check(wdc, 32'h1);
      check(halt_mode, 32'h1);
      @(posedge pclk);
      check(wdc, 32'h0);
      st_chk(8'h35);
      apb(MISE_REG_ACC, 32'h77, 1'b1);
      ex_op(MISE_OP_TMODE, 1'b0, 8'h00);
      @(posedge pclk);
      check(t0m, 32'h3C);
      apb(MISE_REG_CTRL, 32'h1, 1'b1);
      @(posedge pclk);
      check(halt_mode, 32'h0);
      print_verdict;
   end
endmodule // tb
bind mise_core mise_core_assertions chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .prdata(prdata), .pslverr(pslverr), .timer0_mode_register(timer0_mode_register),
   .halt_mode(halt_mode), .watchdog_clear(watchdog_clear));
